//--- core/rsm_core.sv
// Reset sequencer and supply monitor with its control registers
`include "rsm_defs.svh"
`default_nettype none

// Operation
// R1: In reset, halt core, reset registers, force port pins, disable interrupts and timers.
// R2: Reset never clears data memory; only the stack pointer is reinitialised by core reset.
// R3: In reset, port latches are all ones, open-drain, weak pullups on during and after.
// R4: Power-on and supply-monitor resets drive the reset pin low throughout.
// R5: On exit, program counter cleared, internal oscillator selected, fetch starts at zero.
// R6: On leaving any reset, watchdog enabled and clocked by system clock over twelve.
// R7: At power-up stay in reset until supply is good, then add the release delay.
// R8: Power-on exit sets the power-on flag; any other reset clears it.
// R9: After power-on the supply monitor is enabled and selected as reset source.
// R10: Selected monitor with low supply holds reset and pin low until supply returns.
// R11: Monitor enable survives all resets except power-on.
// R12: Flash erase or write with monitor disabled causes a flash-error reset.
// R13: Software enables the monitor before selecting it, else a reset may follow.
// R14: Software enables, waits about five microseconds, then writes one to the flag position.
// R15: Leaving a supply-monitor reset adds no power-on release delay.
// R16: Software writes to the reset-cause register should always set the flag bit.
// R17: Control bit 7 switches the monitor; it resets only when also selected.
// R18: Flash-writing software selects the higher threshold and the monitor as source.
// R19: Control bit 6 reads the synchronised comparator: one above threshold.
// R20: Control bits 4 to 0 ignore writes and read back as zero.
module rsm_core #(
  parameter int unsigned POR_DELAY_CYCLES = `RSM_POR_DELAY_CYCLES
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire rsm_pkg::rsm_sfr_req_s sfr_req_i,
  output logic [7:0]                 sfr_rdata_o,
  input  wire logic                  supply_good_i,
  input  wire logic                  other_reset_i,
  input  wire logic                  flash_write_i,
  output logic                       core_reset_o,
  output logic                       rst_pin_o,
  output logic                       rst_pin_oe_o,
  output logic [7:0]                 port_latch_o,
  output logic                       port_open_drain_o,
  output logic                       weak_pullup_o,
  output logic                       irq_timer_disable_o,
  output logic [15:0]                boot_addr_o,
  output logic                       clk_sel_internal_o,
  output logic                       wdt_enable_o,
  output logic                       wdt_tick_o,
  output logic                       supply_monitor_enable_o,
  output logic                       supply_threshold_select_o,
  output logic                       flash_error_o
);
  import rsm_pkg::*;

  // Counter width and last counts of the release delay and the watchdog divider
  localparam int unsigned CW = 17;
  localparam logic [CW-1:0] POR_LAST = CW'(POR_DELAY_CYCLES - 1);
  localparam logic [3:0] WDT_LAST = 4'(`RSM_WDT_DIVIDE - 1);

  // Sequencer, monitor control, flag and read-back state
  rsm_state_e    state_reg, state_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic [3:0]    wdt_cnt_reg, wdt_cnt_next;
  logic          mon_en_reg, mon_en_next;
  logic          mon_lvl_reg, mon_lvl_next;
  logic          mon_sel_reg, mon_sel_next;
  logic          por_flag_reg, por_flag_next;
  logic [7:0]    rdata_reg, rdata_next;
  logic          in_rst_next, pin_low_next, ferr_next, tick_next;
  logic          supply_good;

  // Comparator output crosses into the clock domain
  rsm_sync2 i_rsm_sync2 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (supply_good_i),
    .sync_o  (supply_good)
  );

  // Register address match, shared by the write and read paths
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction : addr_hit

  // Next state of sequencer, registers and watchdog divider
  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    mon_en_next   = mon_en_reg;
    mon_lvl_next  = mon_lvl_reg;
    mon_sel_next  = mon_sel_reg;
    por_flag_next = por_flag_reg;
    rdata_next    = rdata_reg;
    ferr_next     = 1'b0;
    case (state_reg)
      RSM_ST_POR_WAIT: begin
        cnt_next = '0;
        if (supply_good) begin
          state_next = RSM_ST_POR_DELAY; // [R7]
        end
      end
      RSM_ST_POR_DELAY: begin
        if (!supply_good) begin
          state_next = RSM_ST_POR_WAIT;
        end else if (cnt_reg >= POR_LAST) begin
          state_next    = RSM_ST_RUN; // [R7]
          por_flag_next = 1'b1;       // [R8]
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      RSM_ST_RUN: begin
        if (mon_en_reg && mon_sel_reg && !supply_good) begin
          state_next    = RSM_ST_SUPPLY_RST; // [R10] [R17] [R13]
          por_flag_next = 1'b0;              // [R8]
        end else if (other_reset_i || (flash_write_i && !mon_en_reg)) begin
          state_next    = RSM_ST_OTHER_RST;  // [R12] [R11]
          por_flag_next = 1'b0;              // [R8]
          ferr_next     = flash_write_i && !mon_en_reg;
        end else if (sfr_req_i.wr) begin
          if (addr_hit(sfr_req_i.addr, `RSM_ADDR_SUPPLY_CTRL)) begin
            mon_en_next  = sfr_req_i.wdata[`RSM_CTRL_ENABLE_BIT]; // [R17]
            mon_lvl_next = sfr_req_i.wdata[`RSM_CTRL_LEVEL_BIT];  // [R20]
          end else if (addr_hit(sfr_req_i.addr, `RSM_ADDR_RESET_CAUSE)) begin
            mon_sel_next = sfr_req_i.wdata[`RSM_CAUSE_POWER_ON_BIT]; // [R14] [R16]
          end
        end
      end
      RSM_ST_SUPPLY_RST: begin
        if (supply_good) begin
          state_next = RSM_ST_RUN; // [R15]
        end
      end
      RSM_ST_OTHER_RST: begin
        state_next = RSM_ST_RUN;
      end
      default: begin
        state_next = RSM_ST_POR_WAIT;
      end
    endcase
    // Register reads, reserved bits as zero
    if (sfr_req_i.rd) begin
      if (addr_hit(sfr_req_i.addr, `RSM_ADDR_SUPPLY_CTRL)) begin
        rdata_next = {mon_en_reg, supply_good, mon_lvl_reg, 5'h00}; // [R19] [R20]
      end else if (addr_hit(sfr_req_i.addr, `RSM_ADDR_RESET_CAUSE)) begin
        rdata_next = {6'h00, por_flag_reg, 1'b0}; // [R8]
      end else begin
        rdata_next = 8'h00;
      end
    end
    // Reset and pin-drive decisions follow the next state
    in_rst_next  = (state_next != RSM_ST_RUN);
    pin_low_next = (state_next == RSM_ST_POR_WAIT) || (state_next == RSM_ST_POR_DELAY) ||
                   (state_next == RSM_ST_SUPPLY_RST); // [R4]
    // Divide-by-twelve watchdog clock, restarted by every reset
    if (in_rst_next || (wdt_cnt_reg == WDT_LAST)) begin
      wdt_cnt_next = 4'h0; // [R6]
    end else begin
      wdt_cnt_next = wdt_cnt_reg + 4'h1;
    end
    tick_next = !in_rst_next && (wdt_cnt_reg == WDT_LAST); // [R6]
  end

  // Register stage; power-on reset sets the monitor defaults
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg                 <= RSM_ST_POR_WAIT;
      cnt_reg                   <= '0;
      wdt_cnt_reg               <= 4'h0;
      mon_en_reg                <= `RSM_CTRL_ENABLE_RESET;  // [R9]
      mon_lvl_reg               <= `RSM_CTRL_LEVEL_RESET;
      mon_sel_reg               <= `RSM_CAUSE_SELECT_RESET; // [R9]
      por_flag_reg              <= 1'b0;
      rdata_reg                 <= 8'h00;
      core_reset_o              <= 1'b1;
      rst_pin_o                 <= 1'b0;
      rst_pin_oe_o              <= 1'b1; // [R4]
      port_latch_o              <= `RSM_PORT_LATCH_RESET;
      port_open_drain_o         <= 1'b1;
      weak_pullup_o             <= 1'b1;
      irq_timer_disable_o       <= 1'b1;
      boot_addr_o               <= `RSM_START_ADDR;
      clk_sel_internal_o        <= 1'b1;
      wdt_enable_o              <= 1'b0;
      wdt_tick_o                <= 1'b0;
      supply_monitor_enable_o   <= `RSM_CTRL_ENABLE_RESET;
      supply_threshold_select_o <= `RSM_CTRL_LEVEL_RESET;
      flash_error_o             <= 1'b0;
    end else begin
      state_reg                 <= state_next;
      cnt_reg                   <= cnt_next;
      wdt_cnt_reg               <= wdt_cnt_next;
      mon_en_reg                <= mon_en_next;   // [R11]
      mon_lvl_reg               <= mon_lvl_next;
      mon_sel_reg               <= mon_sel_next;
      por_flag_reg              <= por_flag_next;
      rdata_reg                 <= rdata_next;
      core_reset_o              <= in_rst_next;   // [R1] [R2]
      rst_pin_o                 <= 1'b0;
      rst_pin_oe_o              <= pin_low_next;  // [R4] [R10]
      port_latch_o              <= `RSM_PORT_LATCH_RESET;
      port_open_drain_o         <= in_rst_next;   // [R3]
      weak_pullup_o             <= 1'b1;          // [R3]
      irq_timer_disable_o       <= in_rst_next;   // [R1]
      boot_addr_o               <= `RSM_START_ADDR; // [R5]
      // Any reset returns the system clock to the internal oscillator
      if (in_rst_next) begin
        clk_sel_internal_o      <= 1'b1;          // [R5]
      end
      wdt_enable_o              <= !in_rst_next;  // [R6]
      wdt_tick_o                <= tick_next;
      supply_monitor_enable_o   <= mon_en_next;
      supply_threshold_select_o <= mon_lvl_next;  // [R18]
      flash_error_o             <= ferr_next;     // [R12]
    end
  end

  // Read data straight from its register
  assign sfr_rdata_o = rdata_reg;

endmodule : rsm_core

`default_nettype wire

//--- core/rsm_defs.svh
// Constants for the reset and supply monitor: offsets, fields, reset values and timing
`ifndef RSM_DEFS_SVH
`define RSM_DEFS_SVH

// Register addresses on the special-function bus
`define RSM_ADDR_SUPPLY_CTRL    8'hff
`define RSM_ADDR_RESET_CAUSE    8'hef

// Field positions in supply_monitor_control
`define RSM_CTRL_ENABLE_BIT     7
`define RSM_CTRL_STATUS_BIT     6
`define RSM_CTRL_LEVEL_BIT      5

// Field position of power_on_flag in reset_cause_register
`define RSM_CAUSE_POWER_ON_BIT  1

// Values forced while in reset and on exit
`define RSM_PORT_LATCH_RESET    8'hff
`define RSM_START_ADDR          16'h0000
`define RSM_CTRL_ENABLE_RESET   1'b1
`define RSM_CTRL_LEVEL_RESET    1'b0
`define RSM_CAUSE_SELECT_RESET  1'b1

// Timing: clock period and the power-on release delay
`define RSM_CLK_PERIOD_NS       4
`define RSM_POR_DELAY_NS        300000
`define RSM_POR_DELAY_CYCLES    (`RSM_POR_DELAY_NS / `RSM_CLK_PERIOD_NS)

// Watchdog clock divider
`define RSM_WDT_DIVIDE          12

`endif

//--- core/rsm_pkg.sv
// Types shared by the reset and supply monitor files
`default_nettype none

package rsm_pkg;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    RSM_ST_POR_WAIT   = 5'h01,
    RSM_ST_POR_DELAY  = 5'h02,
    RSM_ST_RUN        = 5'h04,
    RSM_ST_SUPPLY_RST = 5'h08,
    RSM_ST_OTHER_RST  = 5'h10
  } rsm_state_e;

  // Special-function register access from the processor
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } rsm_sfr_req_s;

endpackage : rsm_pkg

`default_nettype wire

//--- core/rsm_sync2.sv
// Two-flop synchroniser for one asynchronous level
`default_nettype none

module rsm_sync2 (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output logic      sync_o
);

  logic meta_reg;

  // First flop feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      sync_o   <= 1'b0;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule : rsm_sync2

`default_nettype wire

//--- verification/rsm_core_chk.sv
// Port assertions for the reset and supply monitor core
`default_nettype none
module rsm_core_chk
  import rsm_pkg::*;
#(
  parameter int unsigned POR_DELAY_CYCLES = 4
) (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire rsm_pkg::rsm_sfr_req_s sfr_req_i,
  input wire logic [7:0]            sfr_rdata_o,
  input wire logic                  other_reset_i,
  input wire logic                  flash_write_i,
  input wire logic                  core_reset_o,
  input wire logic                  rst_pin_o,
  input wire logic                  rst_pin_oe_o,
  input wire logic [7:0]            port_latch_o,
  input wire logic                  port_open_drain_o,
  input wire logic                  weak_pullup_o,
  input wire logic                  irq_timer_disable_o,
  input wire logic [15:0]           boot_addr_o,
  input wire logic                  wdt_enable_o,
  input wire logic                  wdt_tick_o,
  input wire logic                  supply_monitor_enable_o,
  input wire logic                  flash_error_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Pin state, reset entry and exit, watchdog and register relations
  latch_pullup_a: assert property (port_latch_o == 8'hff && weak_pullup_o) else $error("port latch wrong");
  reset_quiet_a: assert property (core_reset_o |-> irq_timer_disable_o && port_open_drain_o && !wdt_enable_o)
    else $error("reset state outputs wrong");
  run_start_a: assert property (!core_reset_o |-> wdt_enable_o && boot_addr_o == 16'h0000)
    else $error("run outputs wrong");
  pin_low_a: assert property (rst_pin_oe_o |-> core_reset_o && !rst_pin_o) else $error("pin drive wrong");
  tick_gap_a: assert property (wdt_tick_o |=> !wdt_tick_o [*8]) else $error("watchdog tick too close");
  other_entry_a: assert property (!core_reset_o && other_reset_i |=> core_reset_o) else $error("reset missed");
  flash_err_a: assert property (!core_reset_o && flash_write_i && !supply_monitor_enable_o |=> flash_error_o
    && core_reset_o) else $error("flash error reset missed");
  no_delay_a: assert property ($fell(rst_pin_oe_o) |-> !core_reset_o) else $error("release delayed");
  enable_kept_a: assert property (core_reset_o |=> $stable(supply_monitor_enable_o))
    else $error("enable changed in reset");
  ctrl_read_a: assert property (sfr_req_i.rd && sfr_req_i.addr == 8'hff |=> sfr_rdata_o[7] ==
    $past(supply_monitor_enable_o) && sfr_rdata_o[4:0] == 5'h00) else $error("control read wrong");
endmodule : rsm_core_chk

bind rsm_core rsm_core_chk #(.POR_DELAY_CYCLES(POR_DELAY_CYCLES)) i_rsm_core_chk (
  .clk_i(clk_i), .rst_i(rst_i), .sfr_req_i(sfr_req_i), .sfr_rdata_o(sfr_rdata_o),
  .other_reset_i(other_reset_i), .flash_write_i(flash_write_i), .core_reset_o(core_reset_o),
  .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o), .port_latch_o(port_latch_o),
  .port_open_drain_o(port_open_drain_o), .weak_pullup_o(weak_pullup_o),
  .irq_timer_disable_o(irq_timer_disable_o), .boot_addr_o(boot_addr_o), .wdt_enable_o(wdt_enable_o),
  .wdt_tick_o(wdt_tick_o), .supply_monitor_enable_o(supply_monitor_enable_o), .flash_error_o(flash_error_o));
`default_nettype wire

//--- verification/rsm_pin_model.sv
// Reset pin pull-up and supply comparator seen from outside the device
`default_nettype none
module rsm_pin_model (
  input  wire logic rst_pin_i,
  input  wire logic rst_pin_oe_i,
  input  wire logic supply_up_i,
  output logic      supply_good_o,
  output logic      rst_pin_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // External pull-up wins unless the device pulls the pin
  assign rst_pin_n_o   = rst_pin_oe_i ? rst_pin_i : 1'b1;
  // Comparator output follows the modelled supply
  assign supply_good_o = supply_up_i;
endmodule : rsm_pin_model
`default_nettype wire

//--- verification/tb_rsm_core.sv
// Self-checking bench for the reset and supply monitor core
`default_nettype none
module tb_rsm_core;
  timeunit 1ns;
  timeprecision 1ps;
  import rsm_pkg::*;
  localparam int unsigned DLY = 4;
  logic clk_i = 1'b0, rst_i = 1'b1, supply_up = 1'b0, other_reset_i = 1'b0, flash_write_i = 1'b0;
  rsm_sfr_req_s sfr_req_i = '0;
  logic [7:0] sfr_rdata_o, port_latch_o, d;
  logic [15:0] boot_addr_o;
  logic core_reset_o, rst_pin_o, rst_pin_oe_o, port_open_drain_o, weak_pullup_o, irq_timer_disable_o;
  logic clk_sel_internal_o, wdt_enable_o, wdt_tick_o, supply_monitor_enable_o, supply_threshold_select_o;
  logic flash_error_o, supply_good, rst_pin_n;
  int miscompares = 0, samples_checked = 0, cycles = 0, n, k;
  rsm_core #(.POR_DELAY_CYCLES(DLY)) i_rsm_core (.clk_i(clk_i), .rst_i(rst_i), .sfr_req_i(sfr_req_i),
    .sfr_rdata_o(sfr_rdata_o), .supply_good_i(supply_good), .other_reset_i(other_reset_i),
    .flash_write_i(flash_write_i), .core_reset_o(core_reset_o), .rst_pin_o(rst_pin_o),
    .rst_pin_oe_o(rst_pin_oe_o), .port_latch_o(port_latch_o), .port_open_drain_o(port_open_drain_o),
    .weak_pullup_o(weak_pullup_o), .irq_timer_disable_o(irq_timer_disable_o), .boot_addr_o(boot_addr_o),
    .clk_sel_internal_o(clk_sel_internal_o), .wdt_enable_o(wdt_enable_o), .wdt_tick_o(wdt_tick_o),
    .supply_monitor_enable_o(supply_monitor_enable_o), .supply_threshold_select_o(supply_threshold_select_o),
    .flash_error_o(flash_error_o));
  rsm_pin_model i_rsm_pin_model (.rst_pin_i(rst_pin_o), .rst_pin_oe_i(rst_pin_oe_o), .supply_up_i(supply_up),
    .supply_good_o(supply_good), .rst_pin_n_o(rst_pin_n));
  // Clock and hang guard
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic wait_reset(input logic v);
    for (n = 0; n < 40 && core_reset_o !== v; n++) tick(1);
  endtask : wait_reset
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] dat);
    @(posedge clk_i);
    sfr_req_i <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: dat};
    @(posedge clk_i);
    sfr_req_i.wr <= 1'b0;
  endtask : sfr_wr
  task automatic sfr_rd(input logic [7:0] a);
    @(posedge clk_i);
    sfr_req_i <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk_i);
    sfr_req_i.rd <= 1'b0;
    #1;
    d = sfr_rdata_o;
  endtask : sfr_rd
  task automatic pulse_in(input bit flash);
    @(posedge clk_i);
    if (flash) begin
      flash_write_i <= 1'b1;
    end else begin
      other_reset_i <= 1'b1;
    end
    @(posedge clk_i);
    {flash_write_i, other_reset_i} <= 2'b00;
    #1;
  endtask : pulse_in
  task automatic set_supply(input logic v);
    @(posedge clk_i);
    supply_up <= v;
    #1;
    wait_reset(~v);
  endtask : set_supply
  // Power-up with a late supply, delay, flags and watchdog
  task automatic t_power_on();
    tick(10);
    check({core_reset_o, rst_pin_n}, 2'b10);
    set_supply(1'b1);
    check(n >= DLY, 1'b1);
    sfr_rd(8'hef);
    check(d, 8'h02);
    sfr_rd(8'hff);
    check(d, 8'hc0);
    check({clk_sel_internal_o, boot_addr_o}, 17'h10000);
    k = 0;
    for (int i = 0; i < 24; i++) begin
      tick(1);
      k += wdt_tick_o;
    end
    check(k, 2);
  endtask : t_power_on
  // Supply dip with the monitor on, then with it off
  task automatic t_supply();
    set_supply(1'b0);
    check({core_reset_o, rst_pin_n}, 2'b10);
    sfr_rd(8'hff);
    check(d, 8'h80);
    set_supply(1'b1);
    check(n < 6, 1'b1);
    sfr_rd(8'hef);
    check(d, 8'h00);
    sfr_wr(8'hff, 8'h3f);
    sfr_rd(8'hff);
    check(d, 8'h60);
    set_supply(1'b0);
    check(core_reset_o, 1'b0);
    set_supply(1'b1);
  endtask : t_supply
  // Other reset keeps the monitor state; flash error only with the monitor off
  task automatic t_other();
    pulse_in(1'b0);
    check({core_reset_o, rst_pin_n}, 2'b11);
    tick(2);
    check({supply_monitor_enable_o, supply_threshold_select_o}, 2'b01);
    pulse_in(1'b1);
    check(flash_error_o, 1'b1);
    tick(2);
    sfr_wr(8'hff, 8'ha0);
    tick(1250);
    check({supply_monitor_enable_o, supply_threshold_select_o}, 2'b11);
    sfr_wr(8'hef, 8'h02);
    pulse_in(1'b1);
    check(flash_error_o, 1'b0);
    set_supply(1'b0);
    check(core_reset_o, 1'b1);
    set_supply(1'b1);
  endtask : t_other
  // Mid-run power-on reset brings back the monitor defaults after software turned them off
  task automatic t_reset();
    sfr_wr(8'hff, 8'h00);
    sfr_wr(8'hef, 8'h00);
    tick(1);
    check({supply_monitor_enable_o, supply_threshold_select_o}, 2'b00);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    check({core_reset_o, supply_monitor_enable_o, rst_pin_n}, 3'b110);
    wait_reset(1'b0);
    check(n >= DLY, 1'b1);
    sfr_rd(8'hef);
    check(d, 8'h02);
    sfr_rd(8'hff);
    check(d, 8'hc0);
    set_supply(1'b0);
    check(core_reset_o, 1'b1);
    set_supply(1'b1);
  endtask : t_reset
  task automatic finish_test();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_power_on();
    t_supply();
    t_other();
    t_reset();
    finish_test();
  end
endmodule : tb_rsm_core
`default_nettype wire
